//--- verilog/sdid_top.sv
// What this block does
// - step/dir mode: one step per chosen edge
// - dual-pulse mode: step line gives clockwise steps
// - step/dir mode: direction level picks rotation sense
// - dual-pulse mode: direction line gives counter-clockwise steps
// - sinking wiring: enable high runs the drive
// - sourcing/differential wiring: enable low runs the drive
// - reset: step/dir, rising edge, sourcing inverts edge
// - current drops to 60% after 2 s idle
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module sdid_top
   import sdid_pkg::*;
#(
   parameter int unsigned IDLE_COUNT = IDLE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic step_pulse_input_i,
   input wire logic direction_input_i,
   input wire logic drive_enable_input_i,
   output logic step_o,
   output logic step_cw_o,
   output logic drive_en_o,
   output logic idle_o,
   output logic [PCT_W-1:0] current_pct_o
);

   if (IDLE_COUNT < 1) begin : g_chk
      $error("sdid_top: IDLE_COUNT must be at least 1");
   end

   // ************************************************************
   // helpers
   // ************************************************************
   // true on the cycle a line enters its active level
   function automatic logic enter_active(input logic cur, input logic prev, input logic active_low);
      enter_active = active_low ? (~cur & prev) : (cur & ~prev);
   endfunction : enter_active

   // byte-lane merge for a register word
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wr[b*8 +: 8];
         end
      end
      lane_merge = res;
   endfunction : lane_merge

   // ************************************************************
   // bus decode
   // ************************************************************
   logic ack_q;
   logic req;
   logic wr_stb;
   logic wr_ctrl;
   logic wr_status;
   logic wr_pos;
   logic wr_idle;

   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   // a write lands at the edge where the master sees ack, not before
   assign wr_stb = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
   assign wr_ctrl = wr_stb & (wb_adr_i == ADR_CTRL);
   assign wr_status = wr_stb & (wb_adr_i == ADR_STATUS);
   assign wr_pos = wr_stb & (wb_adr_i == ADR_POS);
   assign wr_idle = wr_stb & (wb_adr_i == ADR_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   assign wb_ack_o = ack_q;

   // ************************************************************
   // configuration registers
   // ************************************************************
   logic [CTRL_W-1:0] ctrl_q;
   logic [PCT_W-1:0] idle_pct_q;
   logic idle_en_q;
   logic [31:0] ctrl_word;
   logic [31:0] idle_word;
   logic [31:0] ctrl_new;
   logic [31:0] idle_new;

   assign ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl_q};
   assign idle_word = {23'h000000, idle_en_q, 1'b0, idle_pct_q};
   assign ctrl_new = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
   assign idle_new = lane_merge(idle_word, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_new[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_pct_q <= IDLE_PCT_RST;
         idle_en_q <= IDLE_EN_RST;
      end else if (wr_idle) begin
         idle_pct_q <= idle_new[IDLE_PCT_LSB +: PCT_W];
         idle_en_q <= idle_new[IDLE_EN_BIT];
      end
   end

   logic dual_mode;
   logic sourcing;
   logic falling_sel;

   assign dual_mode = ctrl_q[CTRL_MODE_BIT];
   assign sourcing = ctrl_q[CTRL_SRC_BIT];
   assign falling_sel = ctrl_q[CTRL_EDGE_BIT] ^ sourcing;

   // ************************************************************
   // input synchronisation and edges
   // ************************************************************
   logic [2:0] pins;
   logic [2:0] s;
   logic [2:0] prev_q;

   assign pins = {drive_enable_input_i, direction_input_i, step_pulse_input_i};

   sdid_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pins),
      .sync_o(s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 3'h0;
      end else begin
         prev_q <= s;
      end
   end

   // edges ignored until sync stages and delayed copy hold real pin levels
   logic [1:0] warm_q;
   logic armed;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         warm_q <= 2'h0;
      end else if (warm_q != 2'h3) begin
         warm_q <= warm_q + 2'h1;
      end
   end

   assign armed = (warm_q == 2'h3);

   // ************************************************************
   // step decoding
   // ************************************************************
   logic sd_step;
   logic sd_cw;
   logic cw_ev;
   logic ccw_ev;
   logic step_req;
   logic req_cw;

   assign sd_step = enter_active(s[0], prev_q[0], falling_sel);
   assign sd_cw = s[1] ^ ctrl_q[CTRL_DIRINV_BIT];
   assign cw_ev = enter_active(s[0], prev_q[0], ctrl_q[CTRL_CWLOW_BIT]);
   assign ccw_ev = enter_active(s[1], prev_q[1], ctrl_q[CTRL_CCWLOW_BIT]);

   // simultaneous opposite pulses cancel out
   always_comb begin
      if (dual_mode) begin
         step_req = armed & (cw_ev ^ ccw_ev);
         req_cw = cw_ev;
      end else begin
         step_req = armed & sd_step;
         req_cw = sd_cw;
      end
   end

   // ************************************************************
   // enable decoding
   // ************************************************************
   logic en_now;
   logic drive_en_q;

   assign en_now = sourcing ? ~s[2] : s[2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_en_q <= 1'b0;
      end else begin
         drive_en_q <= en_now;
      end
   end

   assign drive_en_o = drive_en_q;

   // ************************************************************
   // step output and position
   // ************************************************************
   logic fire;
   logic step_q;
   logic step_cw_q;
   logic miss_q;
   logic [POS_W-1:0] pos_q;
   logic [POS_W-1:0] pos_base;
   logic [31:0] pos_new;

   assign fire = step_req & drive_en_q;
   assign pos_new = lane_merge(pos_q, wb_dat_i, wb_sel_i);
   assign pos_base = wr_pos ? pos_new : pos_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_q <= 1'b0;
      end else begin
         step_q <= fire;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_cw_q <= 1'b1;
      end else if (fire) begin
         step_cw_q <= req_cw;
      end
   end

   // a step in the same cycle as a load is applied on top of it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_q <= '0;
      end else if (fire) begin
         pos_q <= req_cw ? pos_base + 1'b1 : pos_base - 1'b1;
      end else begin
         pos_q <= pos_base;
      end
   end

   // step while disabled; write one to clear, a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         miss_q <= 1'b0;
      end else if (step_req & ~drive_en_q) begin
         miss_q <= 1'b1;
      end else if (wr_status & wb_sel_i[0] & wb_dat_i[ST_MISS_BIT]) begin
         miss_q <= 1'b0;
      end
   end

   assign step_o = step_q;
   assign step_cw_o = step_cw_q;

   // ************************************************************
   // idle current reduction
   // ************************************************************
   logic expired;
   sdid_state_t state_q;
   logic [PCT_W-1:0] pct_q;

   sdid_idle_timer #(
      .COUNT(IDLE_COUNT)
   ) u_idle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(fire | ~drive_en_q),
      .expired_o(expired)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= SDID_OFF;
      end else begin
         case (state_q)
            SDID_OFF: begin
               if (drive_en_q) begin
                  state_q <= SDID_RUN;
               end
            end
            SDID_RUN: begin
               if (!drive_en_q) begin
                  state_q <= SDID_OFF;
               end else if (expired && idle_en_q && !fire) begin
                  state_q <= SDID_REST;
               end
            end
            SDID_REST: begin
               if (!drive_en_q) begin
                  state_q <= SDID_OFF;
               end else if (fire || !idle_en_q) begin
                  state_q <= SDID_RUN;
               end
            end
            default: begin
               state_q <= SDID_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pct_q <= OFF_PCT;
      end else begin
         case (state_q)
            SDID_RUN: pct_q <= RUN_PCT;
            SDID_REST: pct_q <= idle_pct_q;
            default: pct_q <= OFF_PCT;
         endcase
      end
   end

   assign idle_o = (state_q == SDID_REST);
   assign current_pct_o = pct_q;

   // ************************************************************
   // read data
   // ************************************************************
   logic [31:0] status_word;
   logic [31:0] rd_q;

   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_EN_BIT] = drive_en_q;
      status_word[ST_IDLE_BIT] = idle_o;
      status_word[ST_DIR_BIT] = s[1];
      status_word[ST_LASTCW_BIT] = step_cw_q;
      status_word[ST_MISS_BIT] = miss_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL: rd_q <= ctrl_word;
            ADR_STATUS: rd_q <= status_word;
            ADR_POS: rd_q <= pos_q;
            ADR_IDLE: rd_q <= idle_word;
            default: rd_q <= 32'h00000000;
         endcase
      end
   end

   assign wb_dat_o = rd_q;

endmodule : sdid_top

//--- verilog/sdid_pkg.sv
package sdid_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned IDLE_TIME_MS = 2000;
   localparam int unsigned IDLE_CYCLES = CLK_HZ / 1000 * IDLE_TIME_MS;
   localparam int unsigned MAX_STEP_KHZ = 200;
   localparam int unsigned MIN_STEP_CYCLES = CLK_HZ / (MAX_STEP_KHZ * 1000);

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_POS = 8'h08;
   localparam logic [7:0] ADR_IDLE = 8'h0c;

   // ************************************************************
   // control fields
   // ************************************************************
   localparam int unsigned CTRL_W = 6;
   localparam int unsigned CTRL_MODE_BIT = 0;
   localparam int unsigned CTRL_EDGE_BIT = 1;
   localparam int unsigned CTRL_CWLOW_BIT = 2;
   localparam int unsigned CTRL_CCWLOW_BIT = 3;
   localparam int unsigned CTRL_SRC_BIT = 4;
   localparam int unsigned CTRL_DIRINV_BIT = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   // ************************************************************
   // idle current fields
   // ************************************************************
   localparam int unsigned PCT_W = 7;
   localparam int unsigned IDLE_PCT_LSB = 0;
   localparam int unsigned IDLE_EN_BIT = 8;
   localparam logic [PCT_W-1:0] IDLE_PCT_RST = 7'h3c;
   localparam logic IDLE_EN_RST = 1'b1;
   localparam logic [PCT_W-1:0] RUN_PCT = 7'h64;
   localparam logic [PCT_W-1:0] OFF_PCT = 7'h00;

   // ************************************************************
   // status fields
   // ************************************************************
   localparam int unsigned ST_EN_BIT = 0;
   localparam int unsigned ST_IDLE_BIT = 1;
   localparam int unsigned ST_DIR_BIT = 2;
   localparam int unsigned ST_LASTCW_BIT = 3;
   localparam int unsigned ST_MISS_BIT = 4;

   localparam int unsigned POS_W = 32;

   typedef enum logic [2:0] {
      SDID_OFF = 3'b001,
      SDID_RUN = 3'b010,
      SDID_REST = 3'b100
   } sdid_state_t;

endpackage : sdid_pkg

//--- verilog/sdid_sync.sv
`timescale 1ns/1ns
module sdid_sync #(
   parameter int unsigned WIDTH = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   if (WIDTH < 1) begin : g_chk
      $error("sdid_sync: WIDTH must be at least 1");
   end

   // two flops per line; only the second stage is read outside
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_i[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end

   assign sync_o = sync_q;

endmodule : sdid_sync

//--- verilog/sdid_idle_timer.sv
`timescale 1ns/1ns
module sdid_idle_timer #(
   parameter int unsigned COUNT = 40_000_000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   output logic expired_o
);

   localparam int unsigned CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LIMIT = CW'(COUNT);

   logic [CW-1:0] cnt_q;

   if (COUNT < 1) begin : g_chk
      $error("sdid_idle_timer: COUNT must be at least 1");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         cnt_q <= '0;
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign expired_o = (cnt_q == LIMIT);

endmodule : sdid_idle_timer

//--- dv/sdid_ctrl_model.sv
`timescale 1ns/1ns
// ****
// motion controller pins
// ****
module sdid_ctrl_model (
   input wire logic clk_i,
   output logic step_line_o,
   output logic dir_line_o,
   output logic en_line_o
);
   initial begin
      step_line_o = 1'b0;
      dir_line_o = 1'b0;
      en_line_o = 1'b1;
   end
   // one line moves at a time, 5 us apart, so direction leads the step
   task automatic drive(input logic en, input logic dir, input logic stp);
      en_line_o <= en;
      repeat (sdid_pkg::MIN_STEP_CYCLES) @(posedge clk_i);
      dir_line_o <= dir;
      repeat (sdid_pkg::MIN_STEP_CYCLES) @(posedge clk_i);
      step_line_o <= stp;
      repeat (sdid_pkg::MIN_STEP_CYCLES) @(posedge clk_i);
   endtask : drive
endmodule : sdid_ctrl_model

//--- dv/sdid_top_assertions.sv
`timescale 1ns/1ns
module sdid_top_assertions
   import sdid_pkg::*;
#(
   parameter int unsigned IDLE_COUNT = IDLE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic step_pulse_input_i,
   input wire logic direction_input_i,
   input wire logic step_o,
   input wire logic step_cw_o,
   input wire logic drive_en_o,
   input wire logic idle_o,
   input wire logic [PCT_W-1:0] current_pct_o
);
   localparam int LO = IDLE_COUNT - 2;
   localparam int HI = IDLE_COUNT + 6;
   logic stp_q;
   logic dir_q;
   logic [7:0] chg_q;
   logic [31:0] quiet_q;
   always_ff @(posedge clk_i) begin
      stp_q <= step_pulse_input_i;
      dir_q <= direction_input_i;
   end
   // recent pin activity window
   always_ff @(posedge clk_i) begin
      if (rst_i) chg_q <= 8'h00;
      else chg_q <= {chg_q[6:0], (step_pulse_input_i ^ stp_q) | (direction_input_i ^ dir_q)};
   end
   // cycles since last step or disable
   always_ff @(posedge clk_i) begin
      if (rst_i || step_o || !drive_en_o) quiet_q <= 32'h0;
      else quiet_q <= quiet_q + 32'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_STEP_PULSE:
      assert property (step_o |=> !step_o) else $error("step pulse too long");
   AST_STEP_CAUSE:
      assert property (step_o |-> |chg_q) else $error("step without pin change");
   AST_CW_WITH_STEP:
      assert property ($changed(step_cw_o) |-> step_o) else $error("sense moved without step");
   AST_STEP_EN:
      assert property (step_o |-> drive_en_o) else $error("step while disabled");
   AST_OFF_PCT:
      assert property (!drive_en_o && !$past(drive_en_o) && !$past(drive_en_o, 2) |-> current_pct_o == OFF_PCT)
         else $error("current while disabled");
   AST_IDLE_EARLY:
      assert property ($rose(idle_o) |-> quiet_q >= LO) else $error("idle too early");
   AST_IDLE_LATE:
      assert property (quiet_q == HI |-> idle_o) else $error("idle too late");
   AST_IDLE_PCT:
      assert property ($rose(idle_o) |=> current_pct_o != RUN_PCT) else $error("idle keeps full current");
   AST_STEP_WAKE:
      assert property (step_o |-> ##[1:2] !idle_o) else $error("step left drive idle");
   AST_ACK_REQ:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
endmodule : sdid_top_assertions

bind sdid_top sdid_top_assertions #(.IDLE_COUNT(IDLE_COUNT)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .step_pulse_input_i(step_pulse_input_i), .direction_input_i(direction_input_i), .step_o(step_o),
   .step_cw_o(step_cw_o), .drive_en_o(drive_en_o), .idle_o(idle_o), .current_pct_o(current_pct_o));

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top
   import sdid_pkg::*;
;
   typedef struct packed {logic [5:0] ctrl; logic en; logic dir; logic stp; logic [1:0] n; logic cw;} sdid_row_t;
   localparam int unsigned IDLE_SIM = 300;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic [31:0] rd;
   logic ack, step, step_cw, den, idle, stp_l, dir_l, en_l;
   logic [PCT_W-1:0] pct;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int steps = 0;
   int exp_pos = 0;
   int base;
   // ctrl, enable line, direction line, step line -> steps taken, last sense
   sdid_row_t rows [14] = '{
      '{6'h00, 1'b1, 1'b1, 1'b1, 2'h1, 1'b1}, '{6'h00, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1},
      '{6'h00, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0}, '{6'h02, 1'b1, 1'b0, 1'b0, 2'h1, 1'b0},
      '{6'h02, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0}, '{6'h02, 1'b1, 1'b1, 1'b0, 2'h1, 1'b1},
      '{6'h20, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0}, '{6'h01, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0},
      '{6'h01, 1'b1, 1'b0, 1'b1, 2'h1, 1'b1}, '{6'h01, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0},
      '{6'h0d, 1'b1, 1'b1, 1'b0, 2'h1, 1'b1}, '{6'h0d, 1'b1, 1'b0, 1'b0, 2'h1, 1'b0},
      '{6'h10, 1'b0, 1'b1, 1'b1, 2'h0, 1'b0}, '{6'h10, 1'b0, 1'b1, 1'b0, 2'h1, 1'b1}};

   sdid_top #(.IDLE_COUNT(IDLE_SIM)) u_dut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .step_pulse_input_i(stp_l), .direction_input_i(dir_l), .drive_enable_input_i(en_l),
      .step_o(step), .step_cw_o(step_cw), .drive_en_o(den), .idle_o(idle), .current_pct_o(pct));
   sdid_ctrl_model u_ctl (.clk_i(clk), .step_line_o(stp_l), .dir_line_o(dir_l), .en_line_o(en_l));

   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (step === 1'b1) steps <= steps + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         results();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic results();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   // ****
   // main sequence
   // ****
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, ADR_CTRL, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, ADR_IDLE, 32'h0);
      check(rd, {23'h0, IDLE_EN_RST, 1'b0, IDLE_PCT_RST});
      wb(1'b1, 8'h10, 32'hffffffff);
      wb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 14; i++) begin
         wb(1'b1, ADR_CTRL, {26'h0, rows[i].ctrl});
         base = steps;
         u_ctl.drive(rows[i].en, rows[i].dir, rows[i].stp);
         check(steps - base, rows[i].n);
         check(step_cw, rows[i].cw);
         check(den, 1'b1);
         exp_pos = exp_pos + int'(rows[i].n) * (rows[i].cw ? 1 : -1);
         wb(1'b0, ADR_POS, 32'h0);
         check(rd, exp_pos);
      end
      wb(1'b0, ADR_POS, 32'h0);
      check(rd, exp_pos);
      wb(1'b1, ADR_CTRL, 32'h0);
      u_ctl.drive(1'b1, 1'b1, 1'b0);
      repeat (IDLE_SIM) @(posedge clk);
      check(idle, 1'b1);
      check(pct, IDLE_PCT_RST);
      u_ctl.drive(1'b1, 1'b1, 1'b1);
      check(idle, 1'b0);
      check(pct, RUN_PCT);
      u_ctl.drive(1'b0, 1'b1, 1'b0);
      check(den, 1'b0);
      check(pct, OFF_PCT);
      base = steps;
      u_ctl.drive(1'b0, 1'b1, 1'b1);
      check(steps - base, 32'h0);
      wb(1'b0, ADR_STATUS, 32'h0);
      check(rd & 32'h10, 32'h10);
      wb(1'b1, ADR_STATUS, 32'h10);
      wb(1'b0, ADR_STATUS, 32'h0);
      check(rd & 32'h10, 32'h0);
      wb(1'b1, ADR_CTRL, 32'h3f);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      check({step_cw, den, pct}, {2'h2, OFF_PCT});
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, ADR_CTRL, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, ADR_STATUS, 32'h0);
      check(rd & 32'h10, 32'h0);
      results();
   end
endmodule : tb_top
